// file: design/fpmc_top.sv
`timescale 1ns/1ps
module fpmc_top #(
  parameter int unsigned RUN_TICKS  = fpmc_pkg::RUN_TICKS,
  parameter int unsigned HALT_TICKS = fpmc_pkg::HALT_TICKS,
  parameter bit          HAS_EXTENDER = 1'b1
) (
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic [1:0]  display_select,
  input  wire logic [11:0] switch_reg,
  input  wire logic        timer_on,
  input  wire logic        run_mode,
  input  wire logic        single_clock_mode,
  input  wire logic        interrupt_grant,
  input  wire logic        dma_grant,
  input  wire logic        interrupt_on_instr,
  input  wire logic        return_from_trap_instr,
  input  wire logic        instr_done,
  input  wire logic        addr_load_key,
  input  wire logic        address_decrement_key,
  input  wire logic        field_load_key,
  input  wire logic        deposit_key,
  input  wire logic        examine_key,
  input  wire logic        boot_key,
  input  wire logic        reader_speed_switch,
  input  wire logic        tape_load_active,
  input  wire logic        tape_load_strobe,
  input  wire logic [11:0] tape_load_addr,
  input  wire logic [11:0] tape_load_data,
  input  wire logic [2:0]  tape_load_field,
  input  wire logic [11:0] cpu_pc,
  input  wire logic [11:0] cpu_acc,
  input  wire logic [11:0] cpu_mult_quot,
  input  wire logic        cpu_link,
  input  wire logic        cpu_irq,
  input  wire logic        irq_inhibit_line,
  input  wire logic        intr_inhibit_ff,
  input  wire logic        intr_enable_ff,
  output logic             control_panel_irq,
  output logic             pc_load,
  output logic [11:0]      pc_load_value,
  output logic             mem_rd,
  output logic             mem_wr,
  output logic [11:0]      mem_addr,
  output logic [2:0]       mem_field,
  output logic [11:0]      mem_wdata,
  input  wire logic        mem_ack,
  input  wire logic [11:0] mem_rdata,
  output logic             boot_start,
  output logic [1:0]       boot_select,
  output logic             boot_reader_fast,
  output logic [11:0]      address_lamps,
  output logic [11:0]      data_lamps,
  output logic [2:0]       instr_field,
  output logic [2:0]       data_field
);
  localparam int KEYS = 6;

  logic [KEYS-1:0] key_raw;
  logic [KEYS-1:0] key_s;
  logic [KEYS-1:0] key_d_r;
  logic [KEYS-1:0] key_edge;
  logic [4:0]      lvl_s;
  logic [1:0]      sel_s;
  logic [11:0]     sw_s;
  logic            timer_tick;
  logic            timer_en;

  assign key_raw = {boot_key, examine_key, deposit_key, field_load_key, address_decrement_key, addr_load_key};

  fpmc_sync #(.W(KEYS)) u_key_sync (
    .clk_sys(clk_sys), .rst_b(rst_b), .d(key_raw), .q(key_s)
  );
  fpmc_sync #(.W(5)) u_lvl_sync (
    .clk_sys(clk_sys), .rst_b(rst_b),
    .d({timer_on, run_mode, single_clock_mode, reader_speed_switch, tape_load_active}),
    .q(lvl_s)
  );
  fpmc_sync #(.W(14)) u_sw_sync (
    .clk_sys(clk_sys), .rst_b(rst_b), .d({display_select, switch_reg}), .q({sel_s, sw_s})
  );

  logic timer_on_s, run_s, sngl_s, fast_s, tape_s;
  assign {timer_on_s, run_s, sngl_s, fast_s, tape_s} = lvl_s;

  assign timer_en = timer_on_s && !sngl_s;

  fpmc_timer #(.RUN_TICKS(RUN_TICKS), .HALT_TICKS(HALT_TICKS)) u_timer (
    .clk_sys(clk_sys), .rst_b(rst_b), .enable(timer_en), .run_mode(run_s), .tick(timer_tick)
  );

  // Key edges, accepted only while halted
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) key_d_r <= '0;
    else        key_d_r <= key_s;
  end
  assign key_edge = (key_s & ~key_d_r) & {KEYS{!run_s}};

  // Interrupt gating
  logic shadow_r, shadow_nxt;
  logic tmr_pend_r, tmr_pend_nxt;
  logic gate_ok;

  assign gate_ok = !shadow_r;

  always_comb begin
    shadow_nxt = shadow_r;
    if (interrupt_on_instr || return_from_trap_instr) shadow_nxt = 1'b1;
    else if (instr_done) shadow_nxt = 1'b0;
    tmr_pend_nxt = tmr_pend_r;
    if (timer_tick) tmr_pend_nxt = 1'b1;
    else if (!timer_en) tmr_pend_nxt = 1'b0;
  end

  // Operation sequencer
  fpmc_pkg::fpmc_state_t st_r, st_nxt;
  fpmc_pkg::fpmc_key_t   op_r, op_nxt;
  logic        from_timer_r, from_timer_nxt;
  logic [11:0] pc_r, pc_nxt;
  logic [2:0]  if_r, if_nxt, dfield_r, dfield_nxt;
  logic [11:0] alamp_r, alamp_nxt, dlamp_r, dlamp_nxt;
  logic        irq_r, irq_nxt;
  logic        pcl_r, pcl_nxt;
  logic        boot_r, boot_nxt;
  logic [1:0]  bsel_r, bsel_nxt;
  logic        fast_r, fast_nxt;
  logic        tape_d_r;
  logic [11:0] status_word;
  logic [11:0] sel_value;

  always_comb begin
    status_word = '0;
    status_word[fpmc_pkg::ST_LINK_BIT] = cpu_link;
    status_word[fpmc_pkg::ST_IRQ_BIT]  = cpu_irq && !irq_inhibit_line;
    status_word[fpmc_pkg::ST_INH_BIT]  = intr_inhibit_ff;
    status_word[fpmc_pkg::ST_IEN_BIT]  = intr_enable_ff;
    status_word[fpmc_pkg::ST_IF_LSB +: fpmc_pkg::FIELD_W] = if_r;
    status_word[fpmc_pkg::ST_DFLD_LSB +: fpmc_pkg::FIELD_W] = dfield_r;
    case (fpmc_pkg::fpmc_sel_t'(sel_s))
      fpmc_pkg::FPMC_SEL_ACC:  sel_value = cpu_acc;
      fpmc_pkg::FPMC_SEL_MULQ: sel_value = cpu_mult_quot;
      fpmc_pkg::FPMC_SEL_ST:  sel_value = status_word;
      default:                sel_value = dlamp_r;
    endcase
  end

  logic mem_sel;
  assign mem_sel = (fpmc_pkg::fpmc_sel_t'(sel_s) == fpmc_pkg::FPMC_SEL_MEM);

  always_comb begin
    st_nxt         = st_r;
    op_nxt         = op_r;
    from_timer_nxt = from_timer_r;
    pc_nxt         = pc_r;
    if_nxt         = if_r;
    dfield_nxt     = dfield_r;
    alamp_nxt      = alamp_r;
    dlamp_nxt      = dlamp_r;
    irq_nxt        = 1'b0;
    pcl_nxt        = 1'b0;
    boot_nxt       = 1'b0;
    bsel_nxt       = bsel_r;
    fast_nxt       = fast_r;
    if (tape_s) begin
      if (tape_load_strobe) begin
        alamp_nxt = tape_load_addr;
        dlamp_nxt = tape_load_data;
        pc_nxt    = tape_load_addr;
        dfield_nxt = tape_load_field;
      end
    end else begin
      case (st_r)
        fpmc_pkg::FPMC_ST_IDLE: begin
          if (tape_d_r) begin
            st_nxt = mem_sel ? fpmc_pkg::FPMC_ST_DONE : fpmc_pkg::FPMC_ST_IDLE;
            if (!mem_sel) dlamp_nxt = sel_value;
            from_timer_nxt = 1'b0;
          end else if (key_edge != '0 && gate_ok) begin
            irq_nxt        = 1'b1;
            from_timer_nxt = 1'b0;
            st_nxt         = fpmc_pkg::FPMC_ST_RD;
            if (key_edge[0]) begin
              op_nxt = fpmc_pkg::FPMC_KEY_LOAD;
              pc_nxt = sw_s;
              pcl_nxt = 1'b1;
            end else if (key_edge[1]) begin
              op_nxt = fpmc_pkg::FPMC_KEY_DECR;
              pc_nxt = pc_r - 12'h1;
              pcl_nxt = 1'b1;
            end else if (key_edge[2]) begin
              op_nxt = fpmc_pkg::FPMC_KEY_FLD;
              if (HAS_EXTENDER) begin
                if_nxt = sw_s[fpmc_pkg::SW_IF_LSB +: fpmc_pkg::FIELD_W];
                dfield_nxt = sw_s[fpmc_pkg::SW_DFLD_LSB +: fpmc_pkg::FIELD_W];
              end
            end else if (key_edge[3]) begin
              op_nxt = fpmc_pkg::FPMC_KEY_DEPOSIT;
              st_nxt = fpmc_pkg::FPMC_ST_WR;
            end else if (key_edge[4]) begin
              op_nxt = fpmc_pkg::FPMC_KEY_EXAMINE;
            end else begin
              op_nxt   = fpmc_pkg::FPMC_KEY_BOOT;
              bsel_nxt = {sw_s[fpmc_pkg::SW_BOOT_LSB], sw_s[fpmc_pkg::SW_BOOT_LSB + 1]};
              fast_nxt = !fast_s;
              boot_nxt = 1'b1;
              st_nxt   = fpmc_pkg::FPMC_ST_IDLE;
            end
          end else if (tmr_pend_r && gate_ok && !interrupt_grant && !dma_grant) begin
            irq_nxt        = 1'b1;
            from_timer_nxt = 1'b1;
            op_nxt         = fpmc_pkg::FPMC_KEY_NONE;
            pc_nxt         = cpu_pc;
            st_nxt         = fpmc_pkg::FPMC_ST_RD;
          end
        end
        fpmc_pkg::FPMC_ST_WR: begin
          if (mem_ack) begin
            alamp_nxt = pc_r;
            if (mem_sel) begin
              dlamp_nxt = sw_s;
              pc_nxt    = pc_r + 12'h1;
              pcl_nxt   = 1'b1;
            end else begin
              dlamp_nxt = sel_value;
            end
            st_nxt = fpmc_pkg::FPMC_ST_IDLE;
          end
        end
        fpmc_pkg::FPMC_ST_RD: begin
          alamp_nxt = pc_r;
          st_nxt = mem_sel ? fpmc_pkg::FPMC_ST_RDW : fpmc_pkg::FPMC_ST_IDLE;
          if (!mem_sel) dlamp_nxt = sel_value;
        end
        fpmc_pkg::FPMC_ST_RDW: begin
          if (mem_ack) begin
            dlamp_nxt = mem_rdata;
            if (op_r == fpmc_pkg::FPMC_KEY_EXAMINE) begin
              pc_nxt  = pc_r + 12'h1;
              pcl_nxt = 1'b1;
            end
            st_nxt = fpmc_pkg::FPMC_ST_IDLE;
          end
        end
        fpmc_pkg::FPMC_ST_DONE: begin
          if (mem_ack) begin
            dlamp_nxt = mem_rdata;
            st_nxt    = fpmc_pkg::FPMC_ST_IDLE;
          end
        end
        default: st_nxt = fpmc_pkg::FPMC_ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st_r         <= fpmc_pkg::FPMC_ST_IDLE;
      op_r         <= fpmc_pkg::FPMC_KEY_NONE;
      from_timer_r <= 1'b0;
      pc_r         <= fpmc_pkg::PC_RESET;
      if_r         <= '0;
      dfield_r     <= '0;
      alamp_r      <= '0;
      dlamp_r      <= '0;
      irq_r        <= 1'b0;
      pcl_r        <= 1'b0;
      boot_r       <= 1'b0;
      bsel_r       <= '0;
      fast_r       <= 1'b0;
      shadow_r     <= 1'b0;
      tmr_pend_r   <= 1'b0;
      tape_d_r     <= 1'b0;
    end else begin
      st_r         <= st_nxt;
      op_r         <= op_nxt;
      from_timer_r <= from_timer_nxt;
      pc_r         <= pc_nxt;
      if_r         <= if_nxt;
      dfield_r     <= dfield_nxt;
      alamp_r      <= alamp_nxt;
      dlamp_r      <= dlamp_nxt;
      irq_r        <= irq_nxt;
      pcl_r        <= pcl_nxt;
      boot_r       <= boot_nxt;
      bsel_r       <= bsel_nxt;
      fast_r       <= fast_nxt;
      shadow_r     <= shadow_nxt;
      tmr_pend_r   <= (irq_nxt && from_timer_nxt && !timer_tick) ? 1'b0 : tmr_pend_nxt;
      tape_d_r     <= tape_s;
    end
  end

  // Memory requests; field by cause of interrupt
  always_comb begin
    mem_rd    = (st_r == fpmc_pkg::FPMC_ST_RDW) || (st_r == fpmc_pkg::FPMC_ST_DONE);
    mem_wr    = (st_r == fpmc_pkg::FPMC_ST_WR);
    mem_addr  = pc_r;
    mem_field = (from_timer_r && !mem_wr) ? if_r : dfield_r;
    mem_wdata = sw_s;
  end

  assign control_panel_irq = irq_r;
  assign pc_load           = pcl_r;
  assign pc_load_value     = pc_r;
  assign boot_start        = boot_r;
  assign boot_select       = bsel_r;
  assign boot_reader_fast  = fast_r;
  assign address_lamps     = alamp_r;
  assign data_lamps        = dlamp_r;
  assign instr_field       = if_r;
  assign data_field        = dfield_r;

  a_fld_zero: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !HAS_EXTENDER |-> (if_r == 3'h0 && dfield_r == 3'h0)) else $error("fields changed without extender");
  a_run_no_key: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (run_s && st_r == fpmc_pkg::FPMC_ST_IDLE && !tape_d_r && !tape_s && !tmr_pend_r) |=> !irq_r)
    else $error("key interrupt while running");
  a_grant_block: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (irq_nxt && from_timer_nxt) |-> (!interrupt_grant && !dma_grant)) else $error("timer irq during grant");
  a_shadow_block: assert property (@(posedge clk_sys) disable iff (!rst_b)
    shadow_r |=> !irq_r) else $error("irq after interrupt-on");
  a_sngl_timer: assert property (@(posedge clk_sys) disable iff (!rst_b)
    sngl_s |-> ##1 !timer_tick) else $error("timer ran in single clock");
  a_examine_key_incr: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (st_r == fpmc_pkg::FPMC_ST_RDW && mem_ack && op_r == fpmc_pkg::FPMC_KEY_EXAMINE && !tape_s)
    |=> (pc_r == $past(pc_r) + 12'h1 && data_lamps == $past(mem_rdata))) else $error("examine wrong");
  a_dep_addr: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (mem_wr && mem_ack && !tape_s) |=> (address_lamps == $past(mem_addr))) else $error("lamps mismatch");
  a_tape_show: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (tape_s && tape_load_strobe) |=> (data_lamps == $past(tape_load_data))) else $error("tape data not shown");
endmodule : fpmc_top

// file: design/fpmc_pkg.sv
package fpmc_pkg;
  localparam int unsigned CLK_HZ         = 100_000_000;
  localparam int unsigned RUN_RATE_HZ    = 2;
  localparam int unsigned HALT_RATE_HZ   = 25;
  localparam int unsigned RUN_TICKS      = CLK_HZ / RUN_RATE_HZ;
  localparam int unsigned HALT_TICKS     = CLK_HZ / HALT_RATE_HZ;
  localparam int unsigned WORD_W         = 12;
  localparam int unsigned FIELD_W        = 3;
  localparam int unsigned ST_LINK_BIT    = 0;
  localparam int unsigned ST_IRQ_BIT     = 2;
  localparam int unsigned ST_INH_BIT     = 3;
  localparam int unsigned ST_IEN_BIT     = 4;
  localparam int unsigned ST_IF_LSB      = 6;
  localparam int unsigned ST_DFLD_LSB    = 9;
  localparam int unsigned SW_BOOT_LSB    = 10;
  localparam int unsigned SW_IF_LSB      = 6;
  localparam int unsigned SW_DFLD_LSB    = 9;
  localparam logic [11:0] PC_RESET       = 12'hfff;

  typedef enum logic [1:0] {
    FPMC_SEL_MEM  = 2'b00,
    FPMC_SEL_ACC  = 2'b01,
    FPMC_SEL_MULQ = 2'b10,
    FPMC_SEL_ST   = 2'b11
  } fpmc_sel_t;

  typedef enum logic [1:0] {
    FPMC_BOOT_TAPE   = 2'b00,
    FPMC_BOOT_FLOPPY = 2'b01,
    FPMC_BOOT_CART   = 2'b10,
    FPMC_BOOT_HDISK  = 2'b11
  } fpmc_boot_t;

  typedef enum logic [2:0] {
    FPMC_KEY_NONE    = 3'b000,
    FPMC_KEY_LOAD    = 3'b001,
    FPMC_KEY_DECR    = 3'b010,
    FPMC_KEY_FLD     = 3'b011,
    FPMC_KEY_DEPOSIT = 3'b100,
    FPMC_KEY_EXAMINE = 3'b101,
    FPMC_KEY_BOOT    = 3'b110
  } fpmc_key_t;

  typedef enum logic [2:0] {
    FPMC_ST_IDLE  = 3'b000,
    FPMC_ST_RD    = 3'b001,
    FPMC_ST_RDW   = 3'b010,
    FPMC_ST_WR    = 3'b011,
    FPMC_ST_DONE  = 3'b100
  } fpmc_state_t;
endpackage : fpmc_pkg

// file: design/fpmc_sync.sv
`timescale 1ns/1ps
module fpmc_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_sys,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s1_nxt;
  logic [W-1:0] s2_nxt;

  always_comb begin
    s1_nxt = d;
    s2_nxt = s1_r;
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      s1_r <= '0;
      s2_r <= '0;
    end else begin
      s1_r <= s1_nxt;
      s2_r <= s2_nxt;
    end
  end

  assign q = s2_r;
endmodule : fpmc_sync

// file: design/fpmc_timer.sv
`timescale 1ns/1ps
module fpmc_timer #(
  parameter int unsigned RUN_TICKS  = fpmc_pkg::RUN_TICKS,
  parameter int unsigned HALT_TICKS = fpmc_pkg::HALT_TICKS
) (
  input  wire logic clk_sys,
  input  wire logic rst_b,
  input  wire logic enable,
  input  wire logic run_mode,
  output logic      tick
);
  logic [31:0] cnt_r;
  logic [31:0] cnt_nxt;
  logic [31:0] term;
  logic        tick_nxt;
  logic        tick_r;

  always_comb begin
    term     = run_mode ? 32'(RUN_TICKS - 1) : 32'(HALT_TICKS - 1);
    cnt_nxt  = cnt_r;
    tick_nxt = 1'b0;
    if (!enable) begin
      cnt_nxt = '0;
    end else if (cnt_r >= term) begin
      cnt_nxt  = '0;
      tick_nxt = 1'b1;
    end else begin
      cnt_nxt = cnt_r + 32'h1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r  <= '0;
      tick_r <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tick = tick_r;
endmodule : fpmc_timer

// file: sim/fpmc_cpu_mem_model.sv
`timescale 1ns/1ps
module fpmc_cpu_mem_model (
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic [3:0]  ack_delay,
  input  wire logic        pc_load,
  input  wire logic [11:0] pc_load_value,
  input  wire logic        mem_rd,
  input  wire logic        mem_wr,
  input  wire logic [11:0] mem_addr,
  input  wire logic [2:0]  mem_field,
  input  wire logic [11:0] mem_wdata,
  output logic [11:0]      cpu_pc,
  output logic             mem_ack,
  output logic [11:0]      mem_rdata
);
  logic [11:0] mem_r [logic [14:0]];
  logic [11:0] rdata_r;
  logic [3:0]  wait_r;

  // Unwritten words follow a pattern of field and address
  function automatic logic [11:0] peek(input logic [14:0] k);
    return mem_r.exists(k) ? mem_r[k] : (k[11:0] ^ {k[14:12], 9'h0a5});
  endfunction : peek

  // Data only valid in the acknowledge cycle
  assign mem_rdata = mem_ack ? rdata_r : ~rdata_r;

  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cpu_pc  <= fpmc_pkg::PC_RESET;
      mem_ack <= 1'b0;
      wait_r  <= 4'h0;
      rdata_r <= 12'h000;
    end else begin
      mem_ack <= 1'b0;
      if (pc_load) begin
        cpu_pc <= pc_load_value;
      end
      if ((mem_rd || mem_wr) && !mem_ack) begin
        if (wait_r >= ack_delay) begin
          mem_ack <= 1'b1;
          wait_r  <= 4'h0;
          if (mem_wr) begin
            mem_r[{mem_field, mem_addr}] = mem_wdata;
            rdata_r <= mem_wdata;
          end else begin
            rdata_r <= peek({mem_field, mem_addr});
          end
        end else begin
          wait_r <= wait_r + 4'h1;
        end
      end else begin
        wait_r <= 4'h0;
      end
    end
  end
endmodule : fpmc_cpu_mem_model

// file: sim/front_panel_monitor_control_bench.sv
`timescale 1ns/1ps
module front_panel_monitor_control_bench;
  logic        clk_sys, rst_b, timer_on, run_mode, single_clock_mode, interrupt_grant, dma_grant;
  logic        interrupt_on_instr, return_from_trap_instr, instr_done, reader_speed_switch;
  logic        tape_load_active, tape_load_strobe, cpu_link, cpu_irq, irq_inhibit_line;
  logic        intr_inhibit_ff, intr_enable_ff, control_panel_irq, pc_load, mem_rd, mem_wr;
  logic        mem_ack, boot_start, boot_reader_fast;
  logic [1:0]  display_select, boot_select;
  logic [2:0]  tape_load_field, mem_field, instr_field, data_field;
  logic [3:0]  ack_delay;
  logic [5:0]  keys;
  logic [11:0] switch_reg, tape_load_addr, tape_load_data, cpu_acc, cpu_mult_quot, cpu_pc, pc_load_value;
  logic [11:0] mem_addr, mem_wdata, mem_rdata, address_lamps, data_lamps;
  int          n_fail, n_compared, irq_cnt, boot_cnt, got;

  fpmc_top #(.RUN_TICKS(20), .HALT_TICKS(8), .HAS_EXTENDER(1'b1)) i_dut (
    .clk_sys(clk_sys), .rst_b(rst_b), .display_select(display_select), .switch_reg(switch_reg),
    .timer_on(timer_on), .run_mode(run_mode), .single_clock_mode(single_clock_mode),
    .interrupt_grant(interrupt_grant), .dma_grant(dma_grant), .interrupt_on_instr(interrupt_on_instr),
    .return_from_trap_instr(return_from_trap_instr), .instr_done(instr_done),
    .addr_load_key(keys[0]), .address_decrement_key(keys[1]), .field_load_key(keys[2]),
    .deposit_key(keys[3]), .examine_key(keys[4]), .boot_key(keys[5]),
    .reader_speed_switch(reader_speed_switch), .tape_load_active(tape_load_active),
    .tape_load_strobe(tape_load_strobe), .tape_load_addr(tape_load_addr), .tape_load_data(tape_load_data),
    .tape_load_field(tape_load_field), .cpu_pc(cpu_pc), .cpu_acc(cpu_acc), .cpu_mult_quot(cpu_mult_quot),
    .cpu_link(cpu_link), .cpu_irq(cpu_irq), .irq_inhibit_line(irq_inhibit_line),
    .intr_inhibit_ff(intr_inhibit_ff), .intr_enable_ff(intr_enable_ff), .control_panel_irq(control_panel_irq),
    .pc_load(pc_load), .pc_load_value(pc_load_value), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_addr(mem_addr),
    .mem_field(mem_field), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .boot_start(boot_start), .boot_select(boot_select), .boot_reader_fast(boot_reader_fast),
    .address_lamps(address_lamps), .data_lamps(data_lamps), .instr_field(instr_field), .data_field(data_field));

  fpmc_cpu_mem_model i_mem (
    .clk_sys(clk_sys), .rst_b(rst_b), .ack_delay(ack_delay), .pc_load(pc_load), .pc_load_value(pc_load_value),
    .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_addr(mem_addr), .mem_field(mem_field), .mem_wdata(mem_wdata),
    .cpu_pc(cpu_pc), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    irq_cnt  += (control_panel_irq === 1'b1);
    boot_cnt += (boot_start === 1'b1);
  end

  function automatic logic [11:0] exp_mem(input logic [2:0] f, input logic [11:0] a);
    return a ^ {f, 9'h0a5};
  endfunction : exp_mem

  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic cyc();
    @(posedge clk_sys);
    #1;
  endtask : cyc

  task automatic wait_irq(input int lim);
    int i;
    i = 0;
    while (control_panel_irq !== 1'b1 && i < lim) begin
      cyc();
      i++;
    end
    if (i >= lim) begin
      n_fail++;
      $display("BAD %0t no panel interrupt", $time);
      stop_test();
    end
  endtask : wait_irq

  task automatic settle();
    int i;
    i = 0;
    repeat (2) cyc();
    while ((mem_rd || mem_wr) && i < 40) begin
      cyc();
      i++;
    end
    if (i >= 40) begin
      n_fail++;
      $display("BAD %0t memory access hung", $time);
      stop_test();
    end
    repeat (3) cyc();
  endtask : settle

  task automatic press(input int k, input logic [11:0] sw);
    switch_reg = sw;
    keys[k]    = 1'b1;
    wait_irq(20);
    keys[k] = 1'b0;
    settle();
    repeat (3) cyc();
  endtask : press

  task automatic quiet(input int n, output int cnt);
    cnt = irq_cnt;
    repeat (n) cyc();
    cnt = irq_cnt - cnt;
  endtask : quiet

  initial begin
    {rst_b, timer_on, run_mode, single_clock_mode, interrupt_grant, dma_grant} = 6'h00;
    {interrupt_on_instr, return_from_trap_instr, instr_done, reader_speed_switch} = 4'h0;
    {tape_load_active, tape_load_strobe, tape_load_field, tape_load_addr, tape_load_data} = 29'h0;
    {cpu_link, cpu_irq, irq_inhibit_line, intr_inhibit_ff, intr_enable_ff} = 5'b11001;
    {keys, display_select, switch_reg, ack_delay} = 24'h0;
    cpu_acc = 12'h6b1;
    cpu_mult_quot = 12'h0e2;
    {n_fail, n_compared, irq_cnt, boot_cnt} = 0;
    repeat (20) @(posedge clk_sys);
    #1 rst_b = 1'b1;
    chk(pc_load_value, 12'hfff);
    chk({data_lamps[11:1], control_panel_irq}, 12'h000);
    // Status word and field load
    display_select = 2'b11;
    press(2, 12'h740);
    chk({instr_field, data_field}, 12'h02b);
    chk(data_lamps, 12'h755);
    {irq_inhibit_line, intr_inhibit_ff} = 2'b11;
    ack_delay = 4'h6;
    press(0, 12'h740);
    chk(data_lamps, 12'h759);
    // Load, deposit, examine, decrement with memory shown
    display_select = 2'b00;
    press(0, 12'h123);
    chk({address_lamps, cpu_pc}, {12'h123, 12'h123});
    chk(data_lamps, exp_mem(3'h3, 12'h123));
    ack_delay = 4'h0;
    press(3, 12'h5a5);
    chk({address_lamps, data_lamps}, {12'h123, 12'h5a5});
    chk(cpu_pc, 12'h124);
    press(4, 12'h000);
    chk({address_lamps, data_lamps}, {12'h124, exp_mem(3'h3, 12'h124)});
    chk(cpu_pc, 12'h125);
    press(1, 12'h000);
    chk({address_lamps, cpu_pc}, {12'h124, 12'h124});
    chk(data_lamps, exp_mem(3'h3, 12'h124));
    // Register positions and deposit away from memory position
    display_select = 2'b01;
    press(0, 12'h200);
    chk(data_lamps, cpu_acc);
    display_select = 2'b10;
    press(0, 12'h200);
    chk(data_lamps, cpu_mult_quot);
    display_select = 2'b01;
    press(3, 12'h0f0);
    chk({cpu_pc, data_lamps}, {12'h200, cpu_acc});
    display_select = 2'b00;
    press(4, 12'h000);
    chk({address_lamps, data_lamps}, {12'h200, 12'h0f0});
    // Keys ignored while running
    run_mode = 1'b1;
    repeat (4) cyc();
    keys[0]    = 1'b1;
    switch_reg = 12'h777;
    quiet(20, got);
    keys[0] = 1'b0;
    chk(12'(got), 12'h000);
    chk(cpu_pc, 12'h201);
    run_mode = 1'b0;
    repeat (4) cyc();
    // Loader selection, reader speed per code
    for (int b = 0; b < 4; b++) begin
      reader_speed_switch = b[0];
      press(5, {b[0], b[1], 10'h000});
      chk({boot_reader_fast, boot_select}, {~b[0], b[1:0]});
    end
    chk(12'(boot_cnt), 12'h004);
    // Tape load lamps
    display_select = 2'b01;
    tape_load_active = 1'b1;
    repeat (4) cyc();
    {tape_load_strobe, tape_load_field, tape_load_addr, tape_load_data} = {1'b1, 3'h2, 12'h321, 12'h456};
    cyc();
    tape_load_strobe = 1'b0;
    repeat (3) cyc();
    chk({address_lamps, data_lamps}, {12'h321, 12'h456});
    tape_load_active = 1'b0;
    repeat (8) cyc();
    chk({address_lamps, data_lamps}, {12'h321, cpu_acc});
    // Timer snapshot from instruction field, then rates
    display_select = 2'b00;
    timer_on = 1'b1;
    wait_irq(40);
    settle();
    chk({address_lamps, data_lamps}, {cpu_pc, exp_mem(3'h5, cpu_pc)});
    quiet(160, got);
    chk(12'(got >= 14 && got <= 21), 12'h001);
    run_mode = 1'b1;
    repeat (6) cyc();
    quiet(160, got);
    chk(12'(got >= 5 && got <= 9), 12'h001);
    run_mode = 1'b0;
    // Grants, single clock and post-enable shadow hold the timer back
    for (int g = 0; g < 5; g++) begin
      {return_from_trap_instr, interrupt_on_instr, single_clock_mode, dma_grant, interrupt_grant} = 5'(1 << g);
      cyc();
      {interrupt_on_instr, return_from_trap_instr} = 2'b00;
      repeat (6) cyc();
      quiet(80, got);
      chk(12'(got), 12'h000);
      {interrupt_grant, dma_grant, single_clock_mode, instr_done} = 4'b0001;
      cyc();
      instr_done = 1'b0;
      wait_irq(30);
    end
    // Tape load ending on memory position reads the loaded field
    {timer_on, display_select} = 3'b000;
    repeat (10) cyc();
    tape_load_active = 1'b1;
    repeat (4) cyc();
    {tape_load_strobe, tape_load_field, tape_load_addr, tape_load_data} = {1'b1, 3'h2, 12'h3a0, 12'h000};
    cyc();
    {tape_load_strobe, tape_load_active} = 2'b00;
    repeat (10) cyc();
    chk({address_lamps, data_lamps}, {12'h3a0, exp_mem(3'h2, 12'h3a0)});
    stop_test();
  end

  initial begin
    #900000;
    n_fail++;
    $display("BAD %0t run too long", $time);
    stop_test();
  end
endmodule : front_panel_monitor_control_bench
